// [hw/pin_sync.sv]
// Purpose: Three-flop synchroniser with agreement filter for one pin.
// Assumes: Pin is asynchronous to clk_sys.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module pin_sync #(
	parameter logic INIT_VAL = 1'b0 // Idle level of the pin, loaded at reset so no false edge follows.
) (
	input  wire logic clk_sys, // System clock.
	input  wire logic rstN,    // Synchronised reset.
	input  wire logic pinIn,   // Raw pin.
	output logic      level,   // Filtered level.
	output logic      rise,    // One-cycle pulse on rising change.
	output logic      fall     // One-cycle pulse on falling change.
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			s1_reg <= INIT_VAL;
			s2_reg <= INIT_VAL;
			s3_reg <= INIT_VAL;
			level  <= INIT_VAL;
		end else begin
			s1_reg <= pinIn;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				level <= s3_reg;
			end
		end
	end

	assign rise = (s2_reg == s3_reg) && s3_reg && !level;
	assign fall = (s2_reg == s3_reg) && !s3_reg && level;
endmodule : pin_sync

// [hw/regmap_tail.sv]
// Purpose: Register-map tail, checksum, output tri-state and sync check of a converter.
// Assumes: SPI mode 1 style: host shifts 24-bit frames, command then data.
// Notes:   Frame = 1 unused bit, write bit, 6-bit address, 16-bit data, MSB first.
// How it works
// - The channel 2 gain-trim low register keeps a writable byte in bits 15:8 and reads zero in bits 7:0.
// - A read-only checksum at 3Eh holds a CRC over the register contents and resets to zero.
// - The serial output is released to high impedance whenever chip select is high.
// - A lost clock edge misaligns only the frame in progress; chip select high returns the engine to idle and clears the bit count.
// - A sync pulse out of step with the conversion period sets the resync fault flag.
// - Unread results overflow a two-entry queue and sample-ready then pulses every second period.
`timescale 1ns/1ps
module regmap_tail
	import regmap_tail_pkg::*;
(
	input  wire logic clk_sys,         // System clock, 20 MHz.
	input  wire logic nrst,            // Asynchronous active-low reset.
	input  wire logic sclk,            // Serial clock pin.
	input  wire logic mosi,            // Serial data in pin.
	input  wire logic csN,             // Chip select pin, active low.
	input  wire logic syncN,           // Sync/reset pin, active low.
	input  wire logic master_clock_input, // Master clock pin.
	output logic      misoOut,         // Serial data out value.
	output logic      misoOe,          // Serial data out enable.
	output logic      sample_ready_pin, // Sample-ready, active low.
	output logic      resync_fault_flag // Sticky resync fault.
);
	logic       rst1_reg;
	logic       rstN;
	pin_in_t    pinLvl;
	logic       sclkFall;
	logic       syncFall;
	logic       mclkRise;
	logic [23:0] shiftNow;
	logic [7:0]  ch2_gain_trim_low_byte;
	logic [15:0] config_checksum_reg;
	logic [15:0] reservedReg;
	ser_state_t  serState_reg;
	logic [4:0]  bitCnt_reg;
	logic [23:0] shiftIn_reg;
	logic [15:0] shiftOut_reg;
	logic [12:0] periodCnt_reg;
	logic [1:0]  queueCnt_reg;
	logic        skipPulse_reg;
	logic        frameDone;
	logic        rdWord;
	logic [15:0] crcNext;
	logic [15:0] readMux;

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rst1_reg <= 1'b0;
			rstN     <= 1'b0;
		end else begin
			rst1_reg <= 1'b1;
			rstN     <= rst1_reg;
		end
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	pin_sync #(.INIT_VAL(1'b0)) u_sclk (.clk_sys(clk_sys), .rstN(rstN), .pinIn(sclk),
		.level(pinLvl.sclk), .rise(), .fall(sclkFall));
	pin_sync #(.INIT_VAL(1'b0)) u_mosi (.clk_sys(clk_sys), .rstN(rstN), .pinIn(mosi),
		.level(pinLvl.mosi), .rise(), .fall());
	pin_sync #(.INIT_VAL(1'b1)) u_cs (.clk_sys(clk_sys), .rstN(rstN), .pinIn(csN),
		.level(pinLvl.csN), .rise(), .fall());
	pin_sync #(.INIT_VAL(1'b1)) u_sync (.clk_sys(clk_sys), .rstN(rstN), .pinIn(syncN),
		.level(pinLvl.syncN), .rise(), .fall(syncFall));
	pin_sync #(.INIT_VAL(1'b0)) u_mclk (.clk_sys(clk_sys), .rstN(rstN), .pinIn(master_clock_input),
		.level(pinLvl.mclk), .rise(mclkRise), .fall());

	// ----------------------------------------
	// Serial frame engine
	// ----------------------------------------
	// Frame bits so far plus the bit sampled this cycle, so decode sees the current frame, not a stale one.
	assign shiftNow  = {shiftIn_reg[22:0], pinLvl.mosi};
	assign frameDone = (serState_reg == SER_DATA) && sclkFall && (bitCnt_reg == 5'(FRAME_BITS - 1));
	assign rdWord    = frameDone && !shiftNow[22];

	always_comb begin
		case (shiftNow[5:0])
			CH2_GAIN_TRIM_LOW_ADDR:   readMux = {ch2_gain_trim_low_byte, 8'h00};
			CONFIG_CHECKSUM_ADDR:     readMux = config_checksum_reg;
			RESERVED_WRITE_ZERO_ADDR: readMux = reservedReg;
			default:                  readMux = 16'h0000;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			serState_reg <= SER_IDLE;
			bitCnt_reg   <= 5'd0;
			shiftIn_reg  <= 24'h000000;
			shiftOut_reg <= 16'h0000;
		end else if (pinLvl.csN) begin
			serState_reg <= SER_IDLE;
			bitCnt_reg   <= 5'd0;
		end else begin
			case (serState_reg)
				SER_IDLE: begin
					serState_reg <= SER_CMD;
					bitCnt_reg   <= 5'd0;
				end
				SER_CMD: begin
					if (sclkFall) begin
						shiftIn_reg <= {shiftIn_reg[22:0], pinLvl.mosi};
						bitCnt_reg  <= bitCnt_reg + 5'd1;
						if (bitCnt_reg == 5'd7) begin
							serState_reg <= SER_DATA;
							shiftOut_reg <= readMux;
						end
					end
				end
				SER_DATA: begin
					if (sclkFall) begin
						shiftIn_reg  <= {shiftIn_reg[22:0], pinLvl.mosi};
						shiftOut_reg <= {shiftOut_reg[14:0], 1'b0};
						bitCnt_reg   <= frameDone ? 5'd0 : bitCnt_reg + 5'd1;
						if (frameDone) begin
							serState_reg <= SER_CMD;
						end
					end
				end
				default: serState_reg <= SER_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			misoOut <= 1'b0;
			misoOe  <= 1'b0;
		end else begin
			misoOe  <= !pinLvl.csN;
			misoOut <= (serState_reg == SER_DATA) ? shiftOut_reg[15] : 1'b0;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			ch2_gain_trim_low_byte <= GAIN_TRIM_RESET;
			reservedReg            <= RESERVED_RESET;
		end else if (frameDone && shiftNow[22]) begin
			if (shiftNow[21:16] == CH2_GAIN_TRIM_LOW_ADDR) begin
				ch2_gain_trim_low_byte <= shiftNow[15:8];
			end
			if (shiftNow[21:16] == RESERVED_WRITE_ZERO_ADDR) begin
				reservedReg <= shiftNow[15:0];
			end
		end
	end

	// Serial CRC over both writable words, one bit per cycle, restarted each time the set completes.
	logic [4:0]  crcBit_reg;
	logic [15:0] crcAcc_reg;
	logic [31:0] crcSrc;
	assign crcSrc  = {ch2_gain_trim_low_byte, 8'h00, reservedReg};
	assign crcNext = {crcAcc_reg[14:0], 1'b0} ^ ((crcAcc_reg[15] ^ crcSrc[5'd31 - crcBit_reg]) ? CRC_POLY : 16'h0000);

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			crcBit_reg          <= 5'd0;
			crcAcc_reg          <= CRC_SEED;
			config_checksum_reg <= CHECKSUM_RESET;
		end else begin
			crcBit_reg <= crcBit_reg + 5'd1;
			if (crcBit_reg == 5'd31) begin
				config_checksum_reg <= crcNext;
				crcAcc_reg          <= CRC_SEED;
			end else begin
				crcAcc_reg <= crcNext;
			end
		end
	end

	// ----------------------------------------
	// Conversion period, queue and sync check
	// ----------------------------------------
	logic periodEnd;
	assign periodEnd = mclkRise && (periodCnt_reg == CONV_CYCLES - 13'd1);

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			periodCnt_reg     <= 13'd0;
			resync_fault_flag <= 1'b0;
		end else begin
			if (syncFall && periodCnt_reg != 13'd0) begin
				periodCnt_reg     <= 13'd0;
				resync_fault_flag <= 1'b1;
			end else if (periodEnd) begin
				periodCnt_reg <= 13'd0;
			end else if (mclkRise) begin
				periodCnt_reg <= periodCnt_reg + 13'd1;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rstN) begin
		if (!rstN) begin
			queueCnt_reg     <= 2'd0;
			skipPulse_reg    <= 1'b0;
			sample_ready_pin <= 1'b1;
		end else begin
			sample_ready_pin <= 1'b1;
			if (periodEnd) begin
				if (queueCnt_reg == QUEUE_DEPTH) begin
					skipPulse_reg <= !skipPulse_reg;
					if (!skipPulse_reg) begin
						sample_ready_pin <= 1'b0;
					end
				end else begin
					queueCnt_reg     <= queueCnt_reg + 2'd1;
					sample_ready_pin <= 1'b0;
				end
			end else if (rdWord && queueCnt_reg != 2'd0) begin
				queueCnt_reg  <= queueCnt_reg - 2'd1;
				skipPulse_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_hiz_when_deselected;
		@(posedge clk_sys) disable iff (!rstN) pinLvl.csN |=> !misoOe;
	endproperty
	a_hiz_when_deselected: assert property (p_hiz_when_deselected) else $error("output driven while deselected");

	property p_low_byte_zero;
		@(posedge clk_sys) disable iff (!rstN)
			(!pinLvl.csN && serState_reg == SER_CMD && sclkFall && bitCnt_reg == 5'd7
				&& shiftNow[5:0] == CH2_GAIN_TRIM_LOW_ADDR)
			|=> shiftOut_reg[7:0] == 8'h00;
	endproperty
	a_low_byte_zero: assert property (p_low_byte_zero) else $error("gain trim low byte not zero");

	property p_gain_write_lands;
		@(posedge clk_sys) disable iff (!rstN)
			(frameDone && shiftNow[22] && shiftNow[21:16] == CH2_GAIN_TRIM_LOW_ADDR)
			|=> ch2_gain_trim_low_byte == $past(shiftNow[15:8]);
	endproperty
	a_gain_write_lands: assert property (p_gain_write_lands) else $error("gain trim write lost");

	property p_fault_on_bad_sync;
		@(posedge clk_sys) disable iff (!rstN) (syncFall && periodCnt_reg != 13'd0) |=> resync_fault_flag;
	endproperty
	a_fault_on_bad_sync: assert property (p_fault_on_bad_sync) else $error("resync fault not raised");

	property p_queue_bound;
		@(posedge clk_sys) disable iff (!rstN) queueCnt_reg <= QUEUE_DEPTH;
	endproperty
	a_queue_bound: assert property (p_queue_bound) else $error("result queue overran");

	property p_checksum_stable;
		@(posedge clk_sys) disable iff (!rstN) (crcBit_reg != 5'd31) |=> $stable(config_checksum_reg);
	endproperty
	a_checksum_stable: assert property (p_checksum_stable) else $error("checksum changed mid pass");
endmodule : regmap_tail

// [hw/regmap_tail_pkg.sv]
// Purpose: Shared constants and types for the register-map tail and bus-sharing block.
// Assumes: 16-bit registers with 6-bit addresses on the serial port.
// Notes:   Frame length is counted in serial bits; the conversion period is counted in master clock rises.
package regmap_tail_pkg;
	localparam logic [5:0]  CH2_GAIN_TRIM_LOW_ADDR  = 6'h17;
	localparam logic [5:0]  CONFIG_CHECKSUM_ADDR    = 6'h3e;
	localparam logic [5:0]  RESERVED_WRITE_ZERO_ADDR = 6'h3f;
	localparam logic [7:0]  GAIN_TRIM_RESET         = 8'h00;
	localparam logic [15:0] CHECKSUM_RESET          = 16'h0000;
	localparam logic [15:0] RESERVED_RESET          = 16'h0000;
	localparam logic [15:0] CRC_POLY                = 16'h1021;
	localparam logic [15:0] CRC_SEED                = 16'hffff;
	localparam int          FRAME_BITS              = 24;
	localparam int          CONV_PERIOD_NS          = 250000;
	localparam int          CLK_PERIOD_NS           = 50;
	localparam logic [12:0] CONV_CYCLES             = 13'((CONV_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [12:0] CONV_CYCLES_MIN         = 13'd1;
	localparam logic [1:0]  QUEUE_DEPTH             = 2'd2;

	typedef enum logic [1:0] {
		SER_IDLE = 2'b00,
		SER_CMD  = 2'b01,
		SER_DATA = 2'b11
	} ser_state_t;

	typedef struct packed {
		logic       sclk;
		logic       mosi;
		logic       csN;
		logic       syncN;
		logic       mclk;
	} pin_in_t;
endpackage : regmap_tail_pkg

// [tb/spi_host_model.sv]
// Purpose: Host model for the shared serial bus, sync pin and master clock.
// Assumes: This device is the only one selected; chip select is driven per frame.
// Notes:   Pins change 1 ns after a clk_sys rise.
`timescale 1ns/1ps
module spi_host_model (
	input  wire logic clk_sys,  // System clock.
	input  wire logic misoLine, // Resolved data-out line.
	output logic      sclk,     // Serial clock.
	output logic      mosi,     // Serial data to device.
	output logic      csN,      // Chip select, active low.
	output logic      syncN,    // Sync pin, active low.
	output logic      mclk      // Master clock.
);
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		csN = 1'b1;
		syncN = 1'b1;
		mclk = 1'b0;
	end
	always begin
		repeat (3) @(posedge clk_sys);
		#1 mclk = ~mclk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : tick
	// ----------------------------------------
	// One whole frame, command then data.
	// ----------------------------------------
	task automatic xfer(input logic [23:0] tx, output logic [15:0] rx);
		rx = 16'h0000;
		csN = 1'b0;
		tick(4);
		for (int i = 23; i >= 0; i--) begin
			mosi = tx[i];
			sclk = 1'b1;
			tick(4);
			if (i < 16) rx[i] = misoLine;
			sclk = 1'b0;
			tick(4);
		end
		csN = 1'b1;
		mosi = ~mosi;
		tick(8);
	endtask : xfer
	task automatic syncPulse;
		syncN = 1'b0;
		tick(4);
		syncN = 1'b1;
	endtask : syncPulse
endmodule : spi_host_model

// [tb/tb.sv]
// Purpose: Self-checking bench for the register tail and bus-sharing block.
// Assumes: Host model makes every pin; the released data line toggles.
// Notes:   Readback rows come first, then hand-written cases.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
	$display("unexpected %s expected %h seen %h", nm, (e), (g)); end end
module tb;
	import regmap_tail_pkg::*;
	typedef struct packed {
		logic        wr;
		logic [5:0]  addr;
		logic [15:0] wdata;
		logic [15:0] exp;
		logic        useCrc;
	} row_t;
	logic        clk_sys = 1'b0;
	logic        nrst = 1'b0;
	logic        sclk, mosi, csN, syncN, mclk, misoOut, misoOe, sampleReady, fault;
	logic        flip = 1'b0;
	wire         misoLine = misoOe ? misoOut : flip;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          cycles = 0;
	logic [7:0]  gainModel = GAIN_TRIM_RESET;
	logic [15:0] rd;
	row_t        rows [8] = '{
		'{1'b0, 6'h17, 16'h0000, 16'h0000, 1'b0}, '{1'b0, 6'h3f, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 6'h3e, 16'h0000, 16'h0000, 1'b1}, '{1'b1, 6'h17, 16'ha5c3, 16'ha500, 1'b0},
		'{1'b1, 6'h3e, 16'h1234, 16'h0000, 1'b1}, '{1'b1, 6'h3f, 16'h0000, 16'h0000, 1'b0},
		'{1'b0, 6'h20, 16'h0000, 16'h0000, 1'b0}, '{1'b1, 6'h17, 16'hff7e, 16'hff00, 1'b0}};

	regmap_tail DUT (.clk_sys(clk_sys), .nrst(nrst), .sclk(sclk), .mosi(mosi), .csN(csN),
		.syncN(syncN), .master_clock_input(mclk), .misoOut(misoOut), .misoOe(misoOe),
		.sample_ready_pin(sampleReady), .resync_fault_flag(fault));
	spi_host_model host (.clk_sys(clk_sys), .misoLine(misoLine), .sclk(sclk), .mosi(mosi),
		.csN(csN), .syncN(syncN), .mclk(mclk));

	always #25 clk_sys = ~clk_sys;

	task automatic stop_test;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : stop_test

	always @(posedge clk_sys) begin
		flip <= ~flip;
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end

	function automatic logic [15:0] crcOf(input logic [7:0] g);
		logic [31:0] d;
		logic [15:0] c;
		d = {g, 8'h00, RESERVED_RESET};
		c = CRC_SEED;
		for (int i = 31; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
		return c;
	endfunction : crcOf

	// ----------------------------------------
	// Main sequence.
	// ----------------------------------------
	initial begin
		host.tick(16);
		nrst = 1'b1;
		host.tick(8);
		`CHK("misoOe idle", 1'b0, misoOe)
		foreach (rows[k]) begin
			if (rows[k].wr) host.xfer({2'b01, rows[k].addr, rows[k].wdata}, rd);
			if (rows[k].wr && rows[k].addr == CH2_GAIN_TRIM_LOW_ADDR) gainModel = rows[k].wdata[15:8];
			host.tick(40);
			host.xfer({2'b00, rows[k].addr, 16'h0000}, rd);
			`CHK("readback", (rows[k].useCrc ? crcOf(gainModel) : rows[k].exp), rd)
			`CHK("misoOe after frame", 1'b0, misoOe)
			$display("row %0d done", k);
		end
		`CHK("fault before sync", 1'b0, fault)
		host.syncPulse();
		host.tick(10);
		`CHK("fault after stray sync", 1'b1, fault)
		$display("sync test done");
		for (int i = 0; i < 35000 && sampleReady !== 1'b0; i++) host.tick(1);
		`CHK("ready pulse", 1'b0, sampleReady)
		host.tick(1);
		`CHK("ready pulse width", 1'b1, sampleReady)
		$display("ready test done");
		nrst = 1'b0;
		host.tick(2);
		`CHK("reset misoOe", 1'b0, misoOe)
		`CHK("reset fault", 1'b0, fault)
		`CHK("reset ready", 1'b1, sampleReady)
		nrst = 1'b1;
		host.tick(8);
		host.xfer({2'b00, CH2_GAIN_TRIM_LOW_ADDR, 16'h0000}, rd);
		`CHK("gain after reset", 16'h0000, rd)
		$display("reset test done");
		stop_test();
	end
endmodule : tb
